// File: verilog/ssq_consts.vh
`ifndef SSQ_CONSTS_VH
`define SSQ_CONSTS_VH
// Operation
// - after acquisition completes, a convert input rising edge starts conversion
// - open the sample ground switches first, then tie the arrays to ground
// - binary search of 18 bits, MSB first, halving steps down to FS/262144
// - after the search, return to acquisition, present the code, signal busy end
// - conversion timed by an internal clock, never by the serial clock
// - result belongs to the sample taken at its own start edge, no latency
// - 18-bit two's complement codes, midscale 0x00000, one below is 0x3FFFF
// - input above positive full scale saturates at 0x1FFFF
// - input below negative full scale saturates at 0x20000
// - acquisition plus conversion fits 1,330,000 conversions per second
// - a started conversion completes whatever the convert input does

// ----------------------------------------------------------------------------
// resolution and codes
// ----------------------------------------------------------------------------
`define SSQ_RES_BITS      18
`define SSQ_FS_STEPS      262144
`define SSQ_CODE_MID      18'h00000
`define SSQ_CODE_MID_M1   18'h3FFFF
`define SSQ_CODE_POS_FS   18'h1FFFF
`define SSQ_CODE_NEG_FS   18'h20000
`define SSQ_TRIAL_MSB     18'h20000
`define SSQ_TRIAL_NONE    18'h00000

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define SSQ_CLK_NS        4
`define SSQ_THRU_SPS      1330000
`define SSQ_CYCLE_NS      751
`define SSQ_CYCLE_CYC     (`SSQ_CYCLE_NS / `SSQ_CLK_NS)
`define SSQ_ACQ_NS        250
`define SSQ_ACQ_CYC       ((`SSQ_ACQ_NS + `SSQ_CLK_NS - 1) / `SSQ_CLK_NS)
`define SSQ_SWOPEN_NS     8
`define SSQ_SWOPEN_CYC    ((`SSQ_SWOPEN_NS + `SSQ_CLK_NS - 1) / `SSQ_CLK_NS)
`define SSQ_ARRAY_NS      12
`define SSQ_ARRAY_CYC     ((`SSQ_ARRAY_NS + `SSQ_CLK_NS - 1) / `SSQ_CLK_NS)
`define SSQ_STEP_NS       24
`define SSQ_STEP_CYC      ((`SSQ_STEP_NS + `SSQ_CLK_NS - 1) / `SSQ_CLK_NS)
`define SSQ_SYNC_CYC      3
`define SSQ_CONV_MAX_CYC  (`SSQ_SYNC_CYC + `SSQ_SWOPEN_CYC + `SSQ_ARRAY_CYC + 18 * `SSQ_STEP_CYC + 2)
`define SSQ_CONV_MAX_NS   (`SSQ_CONV_MAX_CYC * `SSQ_CLK_NS)

`endif

// File: verilog/ssq_phase_timer.v
`timescale 1ns/1ps
`include "ssq_consts.vh"

module ssq_phase_timer (
  input  wire       sys_clk,
  input  wire       reset_n,
  input  wire       load,
  input  wire [7:0] load_count,
  output wire       tick
);

  reg [7:0] count_q;
  reg       tick_q;

  // --------------------------------------------------------------------------
  // internal conversion clock: one-cycle tick when a loaded count runs out
  // --------------------------------------------------------------------------
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= 8'h00;
      tick_q  <= 1'b0;
    end else if (load) begin
      count_q <= load_count;
      tick_q  <= 1'b0;
    end else begin
      tick_q <= (count_q == 8'h01);
      if (count_q != 8'h00) begin
        count_q <= count_q - 8'h01;
      end
    end
  end

  assign tick = tick_q;

endmodule

// File: verilog/ssq_sequencer.v
`timescale 1ns/1ps
`include "ssq_consts.vh"

module ssq_sequencer (
  input  wire        sys_clk,
  input  wire        reset_n,
  input  wire        convert_start_input,
  input  wire        comparator_in,
  input  wire        over_range_in,
  input  wire        under_range_in,
  output wire        positive_sample_ground_switch,
  output wire        negative_sample_ground_switch,
  output wire        array_on_inputs,
  output wire [17:0] dac_pos_code,
  output wire [17:0] dac_neg_code,
  output wire        acquiring,
  output wire        busy,
  output wire        conv_done,
  output wire [17:0] result_code,
  output wire        result_saturated,
  output wire        result_fresh,
  output wire        start_ignored
);

  // --------------------------------------------------------------------------
  // states and cycle counts
  // --------------------------------------------------------------------------
  localparam [2:0] ST_ACQ    = 3'h0;
  localparam [2:0] ST_OPEN   = 3'h1;
  localparam [2:0] ST_ARRAY  = 3'h2;
  localparam [2:0] ST_SEARCH = 3'h3;

  localparam integer ACQ_I    = `SSQ_ACQ_CYC;
  localparam integer SWOPEN_I = `SSQ_SWOPEN_CYC - 1;
  localparam integer ARRAY_I  = `SSQ_ARRAY_CYC - 1;
  localparam integer STEP_I   = `SSQ_STEP_CYC - 1;

  localparam [6:0] ACQ_CYC    = ACQ_I[6:0];
  localparam [7:0] SWOPEN_CYC = SWOPEN_I[7:0];
  localparam [7:0] ARRAY_CYC  = ARRAY_I[7:0];
  localparam [7:0] STEP_CYC   = STEP_I[7:0];

  // --------------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------------
  reg        cnv_s1_q;
  reg        cnv_s2_q;
  reg        cnv_s3_q;
  reg        cmp_s1_q;
  reg        cmp_s2_q;
  reg        ovr_s1_q;
  reg        ovr_s2_q;
  reg        und_s1_q;
  reg        und_s2_q;

  reg [2:0]  state_q;
  reg [2:0]  state_d;
  reg [6:0]  acq_cnt_q;
  reg [6:0]  acq_cnt_d;
  reg [17:0] mask_q;
  reg [17:0] mask_d;
  reg [17:0] trial_q;
  reg [17:0] trial_d;
  reg [17:0] result_q;
  reg [17:0] result_d;
  reg        sat_q;
  reg        sat_d;
  reg        fresh_q;
  reg        fresh_d;
  reg        busy_q;
  reg        busy_d;
  reg        done_q;
  reg        done_d;
  reg        ign_q;
  reg        ign_d;
  reg        swc_q;
  reg        swc_d;
  reg        arr_q;
  reg        arr_d;
  reg        ovr_hold_q;
  reg        ovr_hold_d;
  reg        und_hold_q;
  reg        und_hold_d;
  reg        acq_q;
  reg        acq_d;
  reg [17:0] dpos_q;
  reg [17:0] dneg_q;

  reg        tmr_load;
  reg [7:0]  tmr_count;
  reg [17:0] keep_code;
  reg [17:0] final_code;

  wire       start_edge;
  wire       acq_done;
  wire       step_tick;

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnv_s1_q <= 1'b0;
      cnv_s2_q <= 1'b0;
      cnv_s3_q <= 1'b0;
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
      ovr_s1_q <= 1'b0;
      ovr_s2_q <= 1'b0;
      und_s1_q <= 1'b0;
      und_s2_q <= 1'b0;
    end else begin
      cnv_s1_q <= convert_start_input;
      cnv_s2_q <= cnv_s1_q;
      cnv_s3_q <= cnv_s2_q;
      cmp_s1_q <= comparator_in;
      cmp_s2_q <= cmp_s1_q;
      ovr_s1_q <= over_range_in;
      ovr_s2_q <= ovr_s1_q;
      und_s1_q <= under_range_in;
      und_s2_q <= und_s1_q;
    end
  end

  assign start_edge = cnv_s2_q & ~cnv_s3_q;
  assign acq_done   = (acq_cnt_q == ACQ_CYC);

  // --------------------------------------------------------------------------
  // internal conversion clock
  // --------------------------------------------------------------------------
  ssq_phase_timer u_timer (
    .sys_clk    (sys_clk),
    .reset_n    (reset_n),
    .load       (tmr_load),
    .load_count (tmr_count),
    .tick       (step_tick)
  );

  // --------------------------------------------------------------------------
  // search arithmetic
  // --------------------------------------------------------------------------
  always @* begin
    if (cmp_s2_q) begin
      keep_code = trial_q;
    end else begin
      keep_code = trial_q & ~mask_q;
    end
    if (ovr_hold_q) begin
      final_code = `SSQ_CODE_POS_FS;
    end else if (und_hold_q) begin
      final_code = `SSQ_CODE_NEG_FS;
    end else begin
      final_code = {~keep_code[17], keep_code[16:0]};
    end
  end

  // --------------------------------------------------------------------------
  // sequencer next state
  // --------------------------------------------------------------------------
  always @* begin
    state_d    = state_q;
    acq_cnt_d  = acq_cnt_q;
    mask_d     = mask_q;
    trial_d    = trial_q;
    result_d   = result_q;
    sat_d      = sat_q;
    fresh_d    = fresh_q;
    busy_d     = busy_q;
    done_d     = 1'b0;
    ign_d      = 1'b0;
    swc_d      = swc_q;
    arr_d      = arr_q;
    ovr_hold_d = ovr_hold_q;
    und_hold_d = und_hold_q;
    acq_d      = acq_q;
    tmr_load   = 1'b0;
    tmr_count  = 8'h00;
    case (state_q)
      ST_ACQ: begin
        if (!acq_done) begin
          acq_cnt_d = acq_cnt_q + 7'h01;
        end
        if (start_edge) begin
          if (acq_done) begin
            state_d    = ST_OPEN;
            swc_d      = 1'b0;
            busy_d     = 1'b1;
            fresh_d    = 1'b0;
            acq_d      = 1'b0;
            ovr_hold_d = ovr_s2_q;
            und_hold_d = und_s2_q;
            tmr_load   = 1'b1;
            tmr_count  = SWOPEN_CYC;
          end else begin
            ign_d = 1'b1;
          end
        end
      end
      ST_OPEN: begin
        ign_d = start_edge;
        if (step_tick) begin
          state_d   = ST_ARRAY;
          arr_d     = 1'b0;
          tmr_load  = 1'b1;
          tmr_count = ARRAY_CYC;
        end
      end
      ST_ARRAY: begin
        ign_d = start_edge;
        if (step_tick) begin
          state_d   = ST_SEARCH;
          mask_d    = `SSQ_TRIAL_MSB;
          trial_d   = `SSQ_TRIAL_MSB;
          tmr_load  = 1'b1;
          tmr_count = STEP_CYC;
        end
      end
      ST_SEARCH: begin
        ign_d = start_edge;
        if (step_tick) begin
          if (mask_q[0]) begin
            state_d   = ST_ACQ;
            swc_d     = 1'b1;
            arr_d     = 1'b1;
            acq_d     = 1'b1;
            acq_cnt_d = 7'h00;
            busy_d    = 1'b0;
            done_d    = 1'b1;
            fresh_d   = 1'b1;
            result_d  = final_code;
            sat_d     = ovr_hold_q | und_hold_q;
            trial_d   = `SSQ_TRIAL_NONE;
            mask_d    = `SSQ_TRIAL_NONE;
          end else begin
            mask_d    = {1'b0, mask_q[17:1]};
            trial_d   = keep_code | {1'b0, mask_q[17:1]};
            tmr_load  = 1'b1;
            tmr_count = STEP_CYC;
          end
        end
      end
      default: begin
        state_d = ST_ACQ;
        swc_d   = 1'b1;
        arr_d   = 1'b1;
        acq_d   = 1'b1;
        busy_d  = 1'b0;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // state registers
  // --------------------------------------------------------------------------
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q    <= ST_ACQ;
      acq_cnt_q  <= 7'h00;
      mask_q     <= `SSQ_TRIAL_NONE;
      trial_q    <= `SSQ_TRIAL_NONE;
      result_q   <= `SSQ_CODE_MID;
      sat_q      <= 1'b0;
      fresh_q    <= 1'b0;
      busy_q     <= 1'b0;
      done_q     <= 1'b0;
      ign_q      <= 1'b0;
      swc_q      <= 1'b1;
      arr_q      <= 1'b1;
      ovr_hold_q <= 1'b0;
      und_hold_q <= 1'b0;
      acq_q      <= 1'b1;
      dpos_q     <= `SSQ_TRIAL_NONE;
      dneg_q     <= `SSQ_CODE_MID_M1;
    end else begin
      state_q    <= state_d;
      acq_cnt_q  <= acq_cnt_d;
      mask_q     <= mask_d;
      trial_q    <= trial_d;
      result_q   <= result_d;
      sat_q      <= sat_d;
      fresh_q    <= fresh_d;
      busy_q     <= busy_d;
      done_q     <= done_d;
      ign_q      <= ign_d;
      swc_q      <= swc_d;
      arr_q      <= arr_d;
      ovr_hold_q <= ovr_hold_d;
      und_hold_q <= und_hold_d;
      acq_q      <= acq_d;
      dpos_q     <= trial_d;
      dneg_q     <= ~trial_d;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign positive_sample_ground_switch = swc_q;
  assign negative_sample_ground_switch = swc_q;
  assign array_on_inputs               = arr_q;
  assign dac_pos_code                  = dpos_q;
  assign dac_neg_code                  = dneg_q;
  assign acquiring                     = acq_q;
  assign busy                          = busy_q;
  assign conv_done                     = done_q;
  assign result_code                   = result_q;
  assign result_saturated              = sat_q;
  assign result_fresh                  = fresh_q;
  assign start_ignored                 = ign_q;

endmodule

// File: testbench/ssq_sequencer_sva.sv
`timescale 1ns/1ps
module ssq_sequencer_sva (
  input wire        sys_clk,
  input wire        reset_n,
  input wire        positive_sample_ground_switch,
  input wire        negative_sample_ground_switch,
  input wire        array_on_inputs,
  input wire [17:0] dac_pos_code,
  input wire [17:0] dac_neg_code,
  input wire        acquiring,
  input wire        busy,
  input wire        conv_done,
  input wire [17:0] result_code,
  input wire        result_saturated,
  input wire        start_ignored
);
  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  reg [7:0] busy_cnt_q;
  function [17:0] low_bit(input [17:0] x);
    low_bit = x & (~x + 18'h00001);
  endfunction
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) busy_cnt_q <= 8'h00;
    else busy_cnt_q <= busy ? busy_cnt_q + 8'h01 : 8'h00;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // --------------------------------------------------------------------------
  // properties
  // --------------------------------------------------------------------------
  a_start_from_acq: assert property ($rose(busy) |-> $past(acquiring))
    else $error("conversion began outside acquisition");
  a_switch_order: assert property ($fell(positive_sample_ground_switch) |->
    array_on_inputs ##1 array_on_inputs ##[1:4] !array_on_inputs)
    else $error("arrays grounded before switches opened");
  a_switch_pair: assert property (positive_sample_ground_switch == negative_sample_ground_switch
    && dac_neg_code == ~dac_pos_code)
    else $error("switch or trial halves disagree");
  a_msb_first: assert property ($fell(array_on_inputs) |->
    (dac_pos_code == 18'h00000)[*2] ##[1:4] dac_pos_code == 18'h20000)
    else $error("search did not open at the top bit");
  a_trial_halves: assert property (busy && $past(dac_pos_code) != 18'h00000
    && $changed(dac_pos_code) && dac_pos_code != 18'h00000 |->
    ((dac_pos_code ^ $past(dac_pos_code)) | low_bit($past(dac_pos_code))) ==
    (low_bit($past(dac_pos_code)) | (low_bit($past(dac_pos_code)) >> 1)))
    else $error("trial step is not half the previous one");
  a_done_to_acq: assert property (conv_done |-> $past(busy) && !busy && acquiring
    && positive_sample_ground_switch && array_on_inputs)
    else $error("completion without return to acquisition");
  a_result_hold: assert property ($changed(result_code) |-> conv_done)
    else $error("result moved without a completion");
  a_sat_codes: assert property (conv_done && result_saturated |->
    result_code == 18'h1FFFF || result_code == 18'h20000)
    else $error("saturated result is not a full scale code");
  a_conv_bound: assert property (busy_cnt_q < 8'h7C)
    else $error("conversion too long");
  a_refused_runs: assert property (start_ignored && busy |=> busy || conv_done)
    else $error("refused edge disturbed the conversion");
endmodule

bind ssq_sequencer ssq_sequencer_sva u_sva (.sys_clk(sys_clk), .reset_n(reset_n),
  .positive_sample_ground_switch(positive_sample_ground_switch),
  .negative_sample_ground_switch(negative_sample_ground_switch),
  .array_on_inputs(array_on_inputs), .dac_pos_code(dac_pos_code),
  .dac_neg_code(dac_neg_code), .acquiring(acquiring), .busy(busy), .conv_done(conv_done),
  .result_code(result_code), .result_saturated(result_saturated),
  .start_ignored(start_ignored));

// File: testbench/ssq_analog_model.sv
`timescale 1ns/1ps
module ssq_analog_model (
  input  wire        sys_clk,
  input  wire        positive_sample_ground_switch,
  input  wire [17:0] dac_pos_code,
  input  wire [17:0] analog_level,
  output reg         comparator_in = 1'b0
);
  reg [17:0] held_q = 18'h00000;
  // tracks the input while switches are closed, holds it once they open
  always @(negedge sys_clk) begin
    if (positive_sample_ground_switch) held_q <= analog_level;
    comparator_in <= (held_q >= dac_pos_code);
  end
endmodule

// File: testbench/ssq_sequencer_tb_top.sv
`timescale 1ns/1ps
module ssq_sequencer_tb_top;
  reg         sys_clk = 1'b0;
  reg         reset_n = 1'b0;
  reg         convert_start_input = 1'b0;
  reg         over_range_in = 1'b0;
  reg         under_range_in = 1'b0;
  reg  [17:0] analog_level = 18'h20000;
  reg         ign_seen = 1'b0;
  wire        comparator_in;
  wire        sw_p, sw_n, arr, acq, busy, done, sat, fresh, ign;
  wire [17:0] dac_p, dac_n, result;
  integer     miscompares = 0;
  integer     samples_checked = 0;
  integer     cycles = 0;
  // --------------------------------------------------------------------------
  // clock, watchdog, instances
  // --------------------------------------------------------------------------
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (ign === 1'b1) ign_seen = 1'b1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      end_sim;
    end
  end
  ssq_sequencer DUT (.sys_clk(sys_clk), .reset_n(reset_n),
    .convert_start_input(convert_start_input), .comparator_in(comparator_in),
    .over_range_in(over_range_in), .under_range_in(under_range_in),
    .positive_sample_ground_switch(sw_p), .negative_sample_ground_switch(sw_n),
    .array_on_inputs(arr), .dac_pos_code(dac_p), .dac_neg_code(dac_n), .acquiring(acq),
    .busy(busy), .conv_done(done), .result_code(result), .result_saturated(sat),
    .result_fresh(fresh), .start_ignored(ign));
  ssq_analog_model PM (.sys_clk(sys_clk), .positive_sample_ground_switch(sw_p),
    .dac_pos_code(dac_p), .analog_level(analog_level), .comparator_in(comparator_in));
  // --------------------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------------------
  task end_sim;
    begin
      $display("checks %0d errors %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  task chk_code(input [17:0] got, input [17:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("[ERR] %0t code %h expected %h", $time, got, exp);
      end
    end
  endtask
  task chk_bit(input got, input exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("[ERR] %0t flag %b expected %b", $time, got, exp);
      end
    end
  endtask
  // mode 1 moves the inputs mid conversion, mode 2 adds a second start edge
  task conv_expect(input [17:0] lvl, input ov, input un, input [1:0] mode,
                   input [17:0] exp, input exp_sat);
    integer n;
    begin
      repeat (70) @(negedge sys_clk);
      analog_level = lvl;
      over_range_in = ov;
      under_range_in = un;
      ign_seen = 1'b0;
      @(negedge sys_clk);
      convert_start_input = 1'b1;
      repeat (20) @(negedge sys_clk);
      convert_start_input = 1'b0;
      if (mode == 2'd1) begin
        analog_level = ~lvl;
        over_range_in = 1'b0;
        under_range_in = 1'b0;
      end
      if (mode == 2'd2) begin
        @(negedge sys_clk);
        convert_start_input = 1'b1;
        repeat (8) @(negedge sys_clk);
        convert_start_input = 1'b0;
      end
      n = 0;
      while (done !== 1'b1 && n < 200) begin
        @(negedge sys_clk);
        n = n + 1;
      end
      chk_bit(done, 1'b1);
      chk_bit(busy, 1'b0);
      chk_code(result, exp);
      chk_bit(sat, exp_sat);
    end
  endtask
  // --------------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------------
  task t_early;
    begin
      repeat (5) @(negedge sys_clk);
      convert_start_input = 1'b1;
      repeat (10) @(negedge sys_clk);
      chk_bit(ign_seen, 1'b1);
      chk_bit(busy, 1'b0);
      convert_start_input = 1'b0;
    end
  endtask
  task t_codes;
    begin
      conv_expect(18'h20000, 1'b0, 1'b0, 2'd0, 18'h00000, 1'b0);
      conv_expect(18'h1FFFF, 1'b0, 1'b0, 2'd0, 18'h3FFFF, 1'b0);
      conv_expect(18'h3FFFF, 1'b0, 1'b0, 2'd0, 18'h1FFFF, 1'b0);
      conv_expect(18'h00000, 1'b0, 1'b0, 2'd0, 18'h20000, 1'b0);
      conv_expect(18'h20001, 1'b0, 1'b0, 2'd0, 18'h00001, 1'b0);
    end
  endtask
  task t_saturate;
    begin
      conv_expect(18'h00000, 1'b1, 1'b0, 2'd0, 18'h1FFFF, 1'b1);
      conv_expect(18'h3FFFF, 1'b0, 1'b1, 2'd0, 18'h20000, 1'b1);
      conv_expect(18'h3FFFF, 1'b1, 1'b1, 2'd0, 18'h1FFFF, 1'b1);
    end
  endtask
  task t_no_latency;
    begin
      conv_expect(18'h2ABCD, 1'b0, 1'b0, 2'd1, 18'h0ABCD, 1'b0);
      conv_expect(18'h00000, 1'b1, 1'b0, 2'd1, 18'h1FFFF, 1'b1);
    end
  endtask
  task t_refuse_hold;
    begin
      conv_expect(18'h12345, 1'b0, 1'b0, 2'd2, 18'h32345, 1'b0);
      chk_bit(ign_seen, 1'b1);
      repeat (50) @(negedge sys_clk);
      chk_code(result, 18'h32345);
      chk_bit(fresh, 1'b1);
      chk_bit(acq, 1'b1);
    end
  endtask
  task t_throughput;
    begin
      repeat (70) @(negedge sys_clk);
      analog_level = 18'h20005;
      over_range_in = 1'b0;
      under_range_in = 1'b0;
      @(negedge sys_clk);
      convert_start_input = 1'b1;
      repeat (20) @(negedge sys_clk);
      convert_start_input = 1'b0;
      // read without busy once the maximum conversion time has passed
      repeat (98) @(negedge sys_clk);
      chk_code(result, 18'h00005);
      chk_bit(busy, 1'b0);
      repeat (68) @(negedge sys_clk);
      analog_level = 18'h1FFF0;
      ign_seen = 1'b0;
      @(negedge sys_clk);
      convert_start_input = 1'b1;
      repeat (20) @(negedge sys_clk);
      convert_start_input = 1'b0;
      chk_bit(busy, 1'b1);
      chk_bit(ign_seen, 1'b0);
      repeat (98) @(negedge sys_clk);
      chk_code(result, 18'h3FFF0);
    end
  endtask
  initial begin
    repeat (3) @(negedge sys_clk);
    reset_n = 1'b1;
    t_early;
    t_codes;
    t_saturate;
    t_no_latency;
    t_refuse_hold;
    t_throughput;
    end_sim;
  end
endmodule
